/* File: rtl/ep2_page2_regs.sv */
/*
  Extended page two register bank with page selection, standard register
  storage, amplitude trim and energy-efficiency controls.
  Assumes all functional inputs come from logic on clock_i.
*/
`timescale 1ns/100ps

module ep2_page2_regs (
  input logic clock_i,
  input logic sys_rst_i,
  input ep2_pkg::ep2_bus_req_s bus_req_i,
  output logic [15:0] bus_rdata_o,
  input ep2_pkg::ep2_speed_e speed_i,
  input ep2_pkg::ep2_lpi_in_s lpi_i,
  output ep2_pkg::ep2_lpi_out_s lpi_o,
  input logic [7:0] indicator_on_i,
  output logic [7:0] indicator_outputs_o,
  output logic [15:0] copper_media_transmit_trim_o,
  output logic te10_enable_o,
  output logic gig_force_link_o
);

  logic [15:0] page_reg;
  logic [15:0] trim_reg;
  logic [15:0] effic_reg;
  logic [15:0] main_reg [0:30];
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic ext_hit;
  logic page2_sel;
  logic [7:0] indicator_reg;
  logic [7:0] indicator_next;
  ep2_pkg::ep2_lpi_out_s lpi_reg;
  ep2_pkg::ep2_lpi_out_s lpi_next;
  logic [15:0] trim_out_reg;
  logic te10_reg;
  logic gig_force_reg;
  logic gig_force_next;
  logic tx_inhibit;
  logic rx_inhibit;
  logic [15:0] main_peek;

  assign page2_sel = (page_reg == ep2_pkg::PAGE_EXT2);
  // Extended window only for 16..30 under page two
  assign ext_hit = page2_sel &&
                   (bus_req_i.addr >= ep2_pkg::EXT_FIRST_ADDR) &&
                   (bus_req_i.addr != ep2_pkg::PAGE_SEL_ADDR);
  assign main_peek = (bus_req_i.addr == ep2_pkg::PAGE_SEL_ADDR) ?
                     16'h0000 : main_reg[bus_req_i.addr];

  // Page select register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      page_reg <= ep2_pkg::PAGE_MAIN;
    end else if (bus_req_i.wr &&
                 bus_req_i.addr == ep2_pkg::PAGE_SEL_ADDR) begin
      page_reg <= bus_req_i.wdata;
    end
  end

  // Standard register storage, reached whenever extended window is off
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < ep2_pkg::MAIN_DEPTH; i++) begin
        main_reg[i] <= ep2_pkg::MAIN_RST;
      end
    end else if (bus_req_i.wr && !ext_hit &&
                 bus_req_i.addr != ep2_pkg::PAGE_SEL_ADDR) begin
      main_reg[bus_req_i.addr] <= bus_req_i.wdata;
    end
  end

  // Amplitude trim register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      trim_reg[15:12] <= ep2_pkg::TRIM_GIG_RST;
      trim_reg[11:8] <= ep2_pkg::TRIM_FAST_RST;
      trim_reg[7:4] <= ep2_pkg::TRIM_TEN_RST;
      trim_reg[3:0] <= ep2_pkg::TRIM_TE_RST;
    end else if (bus_req_i.wr && ext_hit &&
                 bus_req_i.addr == ep2_pkg::TRIM_ADDR) begin
      trim_reg <= bus_req_i.wdata;
    end
  end

  // Efficiency control register, reserved bits held at zero
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      effic_reg <= ep2_pkg::EFF_RST;
    end else if (bus_req_i.wr && ext_hit &&
                 bus_req_i.addr == ep2_pkg::EFFIC_ADDR) begin
      effic_reg <= bus_req_i.wdata & ep2_pkg::EFF_WR_MASK;
    end
  end

  // Read data path
  always_comb begin
    rdata_next = 16'h0000;
    if (bus_req_i.rd) begin
      if (bus_req_i.addr == ep2_pkg::PAGE_SEL_ADDR) begin
        rdata_next = page_reg;
      end else if (ext_hit) begin
        case (bus_req_i.addr)
          ep2_pkg::TRIM_ADDR: rdata_next = trim_reg;
          ep2_pkg::EFFIC_ADDR: rdata_next = effic_reg;
          default: rdata_next = 16'h0000;
        endcase
      end else begin
        rdata_next = main_reg[bus_req_i.addr];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Indicator drive: low when lit unless the group is inverted
  for (genvar g = 0; g < 8; g++) begin : g_ind
    assign indicator_next[g] = ~indicator_on_i[g] ^
        effic_reg[ep2_pkg::EFF_LED_INV_LSB + g / 2];
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      indicator_reg <= 8'hff;
    end else begin
      indicator_reg <= indicator_next;
    end
  end

  // Low-power idle handling
  always_comb begin
    tx_inhibit = 1'b0;
    rx_inhibit = 1'b0;
    case (speed_i)
      ep2_pkg::SPEED_100: begin
        tx_inhibit = effic_reg[ep2_pkg::EFF_FAST_TX_INH_BIT];
        rx_inhibit = effic_reg[ep2_pkg::EFF_FAST_RX_INH_BIT];
      end
      ep2_pkg::SPEED_1000: begin
        tx_inhibit = effic_reg[ep2_pkg::EFF_GIG_TX_INH_BIT];
        rx_inhibit = effic_reg[ep2_pkg::EFF_GIG_RX_INH_BIT];
      end
      default: begin
        tx_inhibit = 1'b0;
        rx_inhibit = 1'b0;
      end
    endcase
  end

  always_comb begin
    lpi_next.gen_lpi = effic_reg[ep2_pkg::EFF_FORCE_LPI_BIT] &
                       lpi_i.mac_tx_idle;
    lpi_next.media_tx_idle = lpi_i.mac_tx_idle &
                             ~effic_reg[ep2_pkg::EFF_FORCE_LPI_BIT];
    lpi_next.media_tx_lpi = (lpi_i.mac_tx_lpi & ~tx_inhibit) |
                            lpi_next.gen_lpi;
    lpi_next.mac_rx_lpi = lpi_i.media_rx_lpi & ~rx_inhibit;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      lpi_reg <= '0;
    end else begin
      lpi_reg <= lpi_next;
    end
  end

  // Forced gigabit link-up without a forced role
  assign gig_force_next = effic_reg[ep2_pkg::EFF_GIG_FORCE_BIT] &
      main_reg[ep2_pkg::BASIC_CTRL_ADDR][ep2_pkg::BASIC_SPEED_MSB_BIT] &
      ~main_reg[ep2_pkg::BASIC_CTRL_ADDR][ep2_pkg::BASIC_SPEED_LSB_BIT];

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gig_force_reg <= 1'b0;
      te10_reg <= 1'b0;
      trim_out_reg <= {ep2_pkg::TRIM_GIG_RST, ep2_pkg::TRIM_FAST_RST,
                       ep2_pkg::TRIM_TEN_RST, ep2_pkg::TRIM_TE_RST};
    end else begin
      gig_force_reg <= gig_force_next;
      te10_reg <= effic_reg[ep2_pkg::EFF_TE_EN_BIT];
      trim_out_reg <= trim_reg;
    end
  end

  assign bus_rdata_o = rdata_reg;
  assign indicator_outputs_o = indicator_reg;
  assign lpi_o = lpi_reg;
  assign copper_media_transmit_trim_o = trim_out_reg;
  assign te10_enable_o = te10_reg;
  assign gig_force_link_o = gig_force_reg;

  // Checks
  a_page_sel_store: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.wr && bus_req_i.addr == 5'h1f && bus_req_i.wdata == 16'h0002
    |=> page2_sel)
    else $error("page two not selected after write");

  a_page_read_back: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.rd && bus_req_i.addr == ep2_pkg::PAGE_SEL_ADDR
    |=> bus_rdata_o == $past(page_reg))
    else $error("page register read back wrong");

  a_ext_trim_read: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.rd && page2_sel && bus_req_i.addr == 5'h10
    |=> bus_rdata_o == $past(trim_reg))
    else $error("page two read missed trim register");

  a_ext_effic_read: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.rd && page2_sel && bus_req_i.addr == ep2_pkg::EFFIC_ADDR
    |=> bus_rdata_o == $past(effic_reg))
    else $error("page two read missed efficiency register");

  a_ext_main_kept: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.wr && page2_sel && bus_req_i.addr == ep2_pkg::TRIM_ADDR
    |=> main_reg[16] == $past(main_reg[16]))
    else $error("page two write reached standard register");

  a_low_map_fixed: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.rd && bus_req_i.addr < 5'h10
    |=> bus_rdata_o == $past(main_peek))
    else $error("low address not mapped to standard");

  a_low_write_lands: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.wr && bus_req_i.addr < ep2_pkg::EXT_FIRST_ADDR
    |=> main_reg[$past(bus_req_i.addr)] == $past(bus_req_i.wdata))
    else $error("low address write not stored");

  a_main_restored: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.wr && bus_req_i.addr == 5'h1f && bus_req_i.wdata == 16'h0000
    ##1 bus_req_i.rd && bus_req_i.addr == 5'h11
    |=> bus_rdata_o == $past(main_reg[17]))
    else $error("main access not restored");

  a_page_zero_store: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.wr && bus_req_i.addr == ep2_pkg::PAGE_SEL_ADDR &&
    bus_req_i.wdata == ep2_pkg::PAGE_MAIN
    |=> !page2_sel)
    else $error("page zero did not close extended window");

  a_main_high_read: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.rd && !page2_sel && bus_req_i.addr >= 5'h10 &&
    bus_req_i.addr != 5'h1f
    |=> bus_rdata_o == $past(main_peek))
    else $error("main upper address not read");

  a_trim_reset_val: assert property (
    @(posedge clock_i) sys_rst_i |=> trim_reg == 16'h02be)
    else $error("trim reset value wrong");

  a_trim_out_reset: assert property (
    @(posedge clock_i) sys_rst_i |=> copper_media_transmit_trim_o == 16'h02be)
    else $error("trim output reset value wrong");

  a_trim_write_out: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.wr && ext_hit && bus_req_i.addr == 5'h10
    |=> ##1 copper_media_transmit_trim_o == $past(bus_req_i.wdata, 2))
    else $error("trim write not reflected at output");

  a_effic_reset: assert property (
    @(posedge clock_i) sys_rst_i |=> effic_reg == ep2_pkg::EFF_RST)
    else $error("efficiency reset value wrong");

  a_te10_follow: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    ##1 te10_enable_o == $past(effic_reg[15]))
    else $error("efficient ten enable mismatch");

  a_led_polarity: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    effic_reg[13:10] == 4'h0 && indicator_on_i[0]
    |=> !indicator_outputs_o[0])
    else $error("indicator not active low");

  a_led_invert: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    effic_reg[ep2_pkg::EFF_LED_INV_LSB] && indicator_on_i[0]
    |=> indicator_outputs_o[0])
    else $error("indicator group not inverted");

  a_force_link_on: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    effic_reg[5] && main_reg[0][6] && !main_reg[0][13]
    |=> gig_force_link_o)
    else $error("forced gigabit link not allowed");

  a_force_link_off: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !effic_reg[ep2_pkg::EFF_GIG_FORCE_BIT]
    |=> !gig_force_link_o)
    else $error("forced gigabit link without enable");

  a_lpi_forced: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    effic_reg[4] && lpi_i.mac_tx_idle
    |=> lpi_o.media_tx_lpi && !lpi_o.media_tx_idle)
    else $error("forced low-power idle not sent");

  a_idle_forward: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !effic_reg[4] |=> lpi_o.media_tx_idle == $past(lpi_i.mac_tx_idle))
    else $error("idle not forwarded");

  a_gen_lpi_off: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !effic_reg[ep2_pkg::EFF_FORCE_LPI_BIT]
    |=> !lpi_o.gen_lpi)
    else $error("generator low-power idle without force");

  a_tx_lpi_block: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    !effic_reg[4] && ((speed_i == ep2_pkg::SPEED_100 && effic_reg[3]) ||
    (speed_i == ep2_pkg::SPEED_1000 && effic_reg[1]))
    |=> !lpi_o.media_tx_lpi)
    else $error("transmit low-power idle not inhibited");

  a_rx_lpi_block: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (speed_i == ep2_pkg::SPEED_100 && effic_reg[2]) ||
    (speed_i == ep2_pkg::SPEED_1000 && effic_reg[0])
    |=> !lpi_o.mac_rx_lpi)
    else $error("receive low-power idle not inhibited");

  a_rx_lpi_pass: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    speed_i == ep2_pkg::SPEED_10
    |=> lpi_o.mac_rx_lpi == $past(lpi_i.media_rx_lpi))
    else $error("receive low-power idle not passed");

  a_reserved_zero: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    bus_req_i.rd && ext_hit && bus_req_i.addr > 5'h11
    |=> bus_rdata_o == 16'h0000)
    else $error("reserved address not zero");

  a_reserved_bits: assert property (
    @(posedge clock_i) disable iff (sys_rst_i)
    (effic_reg & ~ep2_pkg::EFF_WR_MASK) == 16'h0000)
    else $error("reserved efficiency bits not zero");

endmodule : ep2_page2_regs

/* File: rtl/ep2_pkg.sv */
/*
  Package for the extended page two control register bank: management
  addresses, page codes, field positions, reset values and bus carriers.
  Assumes a 32-entry, 16-bit management register space.
*/
package ep2_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int MAIN_DEPTH = 31;

  // Management addresses
  localparam logic [4:0] PAGE_SEL_ADDR = 5'h1f;
  localparam logic [4:0] EXT_FIRST_ADDR = 5'h10;
  localparam logic [4:0] TRIM_ADDR = 5'h10;
  localparam logic [4:0] EFFIC_ADDR = 5'h11;

  // Page select codes
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT2 = 16'h0002;

  // Trim register fields
  localparam int TRIM_GIG_LSB = 12;
  localparam int TRIM_FAST_LSB = 8;
  localparam int TRIM_TEN_LSB = 4;
  localparam int TRIM_TE_LSB = 0;
  localparam logic [3:0] TRIM_GIG_RST = 4'h0;
  localparam logic [3:0] TRIM_FAST_RST = 4'h2;
  localparam logic [3:0] TRIM_TEN_RST = 4'hb;
  localparam logic [3:0] TRIM_TE_RST = 4'he;

  // Efficiency register fields
  localparam int EFF_TE_EN_BIT = 15;
  localparam int EFF_LED_INV_LSB = 10;
  localparam int EFF_GIG_FORCE_BIT = 5;
  localparam int EFF_FORCE_LPI_BIT = 4;
  localparam int EFF_FAST_TX_INH_BIT = 3;
  localparam int EFF_FAST_RX_INH_BIT = 2;
  localparam int EFF_GIG_TX_INH_BIT = 1;
  localparam int EFF_GIG_RX_INH_BIT = 0;
  localparam logic [15:0] EFF_WR_MASK = 16'hbc3f;
  localparam logic [15:0] EFF_RST = 16'h0000;
  localparam logic [15:0] MAIN_RST = 16'h0000;

  // Basic control register bits used by forced gigabit link-up
  localparam logic [4:0] BASIC_CTRL_ADDR = 5'h00;
  localparam int BASIC_SPEED_LSB_BIT = 13;
  localparam int BASIC_SPEED_MSB_BIT = 6;

  typedef enum logic [1:0] {SPEED_10, SPEED_100, SPEED_1000} ep2_speed_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [15:0] wdata;
  } ep2_bus_req_s;

  typedef struct packed {
    logic mac_tx_idle;
    logic mac_tx_lpi;
    logic media_rx_lpi;
  } ep2_lpi_in_s;

  typedef struct packed {
    logic media_tx_idle;
    logic media_tx_lpi;
    logic gen_lpi;
    logic mac_rx_lpi;
  } ep2_lpi_out_s;

endpackage : ep2_pkg

/* File: verif/ep2_page2_regs_tb_top.sv */
/*
  Self-checking bench for the page two register bank: page mapping,
  trim and efficiency registers, indicator polarity and idle control.
  Assumes the design package is compiled before this file.
*/
`timescale 1ns/100ps

module ep2_page2_regs_tb_top;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  ep2_pkg::ep2_bus_req_s bus_req = '0;
  logic [15:0] rdata;
  ep2_pkg::ep2_speed_e speed = ep2_pkg::SPEED_10;
  ep2_pkg::ep2_lpi_in_s lpi_in = '0;
  ep2_pkg::ep2_lpi_out_s lpi_out;
  logic [7:0] ind_on = 8'h00;
  logic [7:0] ind_pins;
  logic [15:0] trim_out;
  logic te10_en;
  logic force_link;
  int failures = 0;
  int checks_done = 0;
  logic [15:0] eff;
  logic [15:0] reg0;
  logic [15:0] val;
  logic [15:0] main16;

  always #25 clock_i = ~clock_i;

  ep2_page2_regs dut (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .bus_req_i(bus_req),
    .bus_rdata_o(rdata),
    .speed_i(speed),
    .lpi_i(lpi_in),
    .lpi_o(lpi_out),
    .indicator_on_i(ind_on),
    .indicator_outputs_o(ind_pins),
    .copper_media_transmit_trim_o(trim_out),
    .te10_enable_o(te10_en),
    .gig_force_link_o(force_link)
  );

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_i);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_i);
    bus_req <= '0;
  endtask : bus_wr

  // Read data stand only in the cycle after the read strobe
  task automatic rd_chk(input string what, input logic [4:0] a,
      input logic [15:0] exp);
    @(posedge clock_i);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock_i);
    bus_req <= '0;
    #1;
    chk(what, exp, rdata);
  endtask : rd_chk

  function automatic logic [7:0] exp_pins(input logic [7:0] on,
      input logic [3:0] inv);
    for (int b = 0; b < 8; b++) begin
      exp_pins[b] = ~on[b] ^ inv[b / 2];
    end
  endfunction : exp_pins

  function automatic logic [3:0] exp_lpi(input ep2_pkg::ep2_speed_e s,
      input logic [15:0] e, input ep2_pkg::ep2_lpi_in_s i);
    logic frc;
    logic ti;
    logic ri;
    frc = e[4] & i.mac_tx_idle;
    ti = (s == ep2_pkg::SPEED_100 & e[3]) | (s == ep2_pkg::SPEED_1000 & e[1]);
    ri = (s == ep2_pkg::SPEED_100 & e[2]) | (s == ep2_pkg::SPEED_1000 & e[0]);
    exp_lpi = {i.mac_tx_idle & ~frc, (i.mac_tx_lpi & ~ti) | frc, frc,
               i.media_rx_lpi & ~ri};
  endfunction : exp_lpi

  initial begin
    repeat (5000) @(posedge clock_i);
    failures++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h9500));
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("trim out", 16'h02be, trim_out);
    chk("pins", 16'h00ff, {8'h00, ind_pins});
    main16 = 16'($urandom);
    bus_wr(5'h10, main16);
    bus_wr(5'h12, ~main16);
    bus_wr(5'h1f, 16'h0002);
    rd_chk("page", 5'h1f, 16'h0002);
    rd_chk("trim", 5'h10, 16'h02be);
    rd_chk("eff", 5'h11, 16'h0000);
    bus_wr(5'h12, 16'hffff);
    rd_chk("reserved", 5'h12, 16'h0000);
    bus_wr(5'h11, 16'hffff);
    rd_chk("eff mask", 5'h11, ep2_pkg::EFF_WR_MASK);
    repeat (20) begin
      val = 16'($urandom);
      bus_wr(5'h10, val);
      rd_chk("trim", 5'h10, val);
      chk("trim out", val, trim_out);
    end
    repeat (40) begin
      eff = 16'($urandom) & ep2_pkg::EFF_WR_MASK;
      reg0 = 16'($urandom);
      bus_wr(5'h00, reg0);
      bus_wr(5'h11, eff);
      rd_chk("reg0", 5'h00, reg0);
      @(posedge clock_i);
      speed <= ep2_pkg::ep2_speed_e'($urandom_range(0, 2));
      lpi_in <= 3'($urandom);
      ind_on <= 8'($urandom);
      repeat (2) @(posedge clock_i);
      #1;
      chk("lpi", {12'h000, exp_lpi(speed, eff, lpi_in)},
          {12'h000, lpi_out});
      chk("pins", {8'h00, exp_pins(ind_on, eff[13:10])},
          {8'h00, ind_pins});
      chk("te10", {15'h0000, eff[15]}, {15'h0000, te10_en});
      chk("force", {15'h0000, eff[5] & reg0[6] & ~reg0[13]},
          {15'h0000, force_link});
    end
    // Any page code other than two keeps the main set
    bus_wr(5'h1f, 16'h0003);
    rd_chk("main16", 5'h10, main16);
    bus_wr(5'h1f, 16'h0000);
    rd_chk("main16", 5'h10, main16);
    rd_chk("main18", 5'h12, ~main16);
    // Page two, back to main, then read 17 with no gap
    bus_wr(5'h11, main16 ^ 16'h00ff);
    @(posedge clock_i);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: 5'h1f, wdata: 16'h0002};
    @(posedge clock_i);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: 5'h1f, wdata: 16'h0000};
    @(posedge clock_i);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: 5'h11, wdata: 16'h0000};
    @(posedge clock_i);
    bus_req <= '0;
    #1;
    chk("main17", main16 ^ 16'h00ff, rdata);
    rd_chk("reg0", 5'h00, reg0);
    bus_wr(5'h10, ~val);
    bus_wr(5'h1f, 16'h0002);
    rd_chk("trim kept", 5'h10, val);
    chk("trim out", val, trim_out);
    tally_and_finish();
  end
endmodule : ep2_page2_regs_tb_top
